// >>> verilog/dms_slice.sv
// Multiply-accumulate slice: pre-adder, signed 25x18 multiplier, 48-bit SIMD
// arithmetic/logic unit with accumulator, pattern detector and cascade buses.
// Assumes operands and controls come from fabric logic on the same clock.
// Controls act at the multiplier and arithmetic stages; operands are registered once on entry, except the cascade input pcin, which feeds Z directly.
//
// How it works
// - Signed 25 by 18 multiply, full product
// - 48-bit accumulator adds result to stored sum
// - Multiplier bypass feeds 48-bit operand directly
// - Lanes of 24 or 12 bits, no crossing carries
// - Logic mode selects one of ten functions
// - Optional pre-adder sums two operands before multiply
// - Pattern match flag, drives convergent rounding
// - Pattern detector plus logic unit: 96-bit functions
// - Accumulator counts up or down when enabled
// - Optional pipeline register, cascade buses to neighbour
`timescale 1ns/1ps
`include "dms_slice_regs.svh"

module dms_slice (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [`DMS_A_W-1:0] a_in,
  input wire logic [`DMS_A_W-1:0] d_in,
  input wire logic [`DMS_B_W-1:0] b_in,
  input wire logic [`DMS_P_W-1:0] c_in,
  input wire logic [`DMS_P_W-1:0] ab_in,
  input wire logic [`DMS_P_W-1:0] pcin,
  input wire logic preadd_en,
  input wire logic preadd_sub,
  input wire logic use_mreg,
  input wire logic mul_bypass,
  input wire logic clr,
  input wire dms_pkg::dms_op_e op,
  input wire dms_pkg::dms_zsel_e zsel,
  input wire dms_pkg::dms_simd_e simd,
  input wire dms_pkg::dms_lfn_e lfn,
  input wire logic [`DMS_P_W-1:0] pattern,
  input wire logic [`DMS_P_W-1:0] pmask,
  input wire logic round_en,
  input wire logic [`DMS_RPOS_W-1:0] round_pos,
  output logic [`DMS_P_W-1:0] p_out,
  output logic [`DMS_P_W-1:0] pcout,
  output logic [`DMS_LANES-1:0] carry_out,
  output logic pattern_match,
  output logic pattern_bmatch
);

  // Lane-aware add: carries only pass chunk borders inside one lane
  function automatic logic [`DMS_LANES+`DMS_P_W-1:0] lane_add(
    input logic [`DMS_P_W-1:0] x,
    input logic [`DMS_P_W-1:0] z,
    input logic sub,
    input dms_pkg::dms_simd_e mode
  );
    logic [`DMS_P_W-1:0] xs;
    logic [`DMS_P_W-1:0] s;
    logic [`DMS_LANES-1:0] co;
    logic c;
    logic start;
    logic [`DMS_LANE_W:0] part;
    xs = sub ? ~x : x;
    s = '0;
    co = '0;
    c = 1'b0;
    for (int k = 0; k < `DMS_LANES; k++) begin
      // A new lane restarts the carry chain with the subtract carry-in
      start = (k == 0) || (mode == dms_pkg::DMS_SIMD_FOUR12) ||
              ((mode == dms_pkg::DMS_SIMD_TWO24) && (k == `DMS_HALF_CHUNK));
      part = {1'b0, z[k*`DMS_LANE_W +: `DMS_LANE_W]} +
             {1'b0, xs[k*`DMS_LANE_W +: `DMS_LANE_W]} +
             {{`DMS_LANE_W{1'b0}}, (start ? sub : c)};
      s[k*`DMS_LANE_W +: `DMS_LANE_W] = part[`DMS_LANE_W-1:0];
      c = part[`DMS_LANE_W];
      co[k] = c;
    end
    return {co, s};
  endfunction

  // A one in the least significant bit of every active lane
  function automatic logic [`DMS_P_W-1:0] lane_one(input dms_pkg::dms_simd_e mode);
    logic [`DMS_P_W-1:0] v;
    v = '0;
    v[0] = 1'b1;
    if (mode == dms_pkg::DMS_SIMD_TWO24) begin
      v[`DMS_HALF_CHUNK*`DMS_LANE_W] = 1'b1;
    end else if (mode == dms_pkg::DMS_SIMD_FOUR12) begin
      for (int k = 1; k < `DMS_LANES; k++) begin
        v[k*`DMS_LANE_W] = 1'b1;
      end
    end
    return v;
  endfunction

  // Pattern compare: masked bits are don't-care
  function automatic logic pat_hit(
    input logic [`DMS_P_W-1:0] v,
    input logic [`DMS_P_W-1:0] pat,
    input logic [`DMS_P_W-1:0] msk
  );
    return &(~(v ^ pat) | msk);
  endfunction

  // Input stage registers
  logic [`DMS_A_W-1:0] a_q, a_d;
  logic [`DMS_A_W-1:0] d_q, d_d;
  logic [`DMS_B_W-1:0] b_q, b_d;
  logic [`DMS_P_W-1:0] c_q, c_d;
  logic [`DMS_P_W-1:0] ab_q, ab_d;
  // Multiplier stage
  logic [`DMS_A_W-1:0] pre_val; // Pre-adder output, wraps at 25 bits
  logic [`DMS_M_W-1:0] prod;    // Full signed product
  logic [`DMS_M_W-1:0] m_q, m_d;
  logic [`DMS_M_W-1:0] m_sel;   // Registered or direct product
  // Arithmetic stage
  logic [`DMS_P_W-1:0] x_op;
  logic [`DMS_P_W-1:0] z_op;
  logic [`DMS_P_W-1:0] logic_val;
  logic [`DMS_LANES+`DMS_P_W-1:0] sum_val;
  logic [`DMS_P_W-1:0] raw_val; // Result before rounding fix-up
  logic raw_hit;
  logic [`DMS_P_W-1:0] p_q, p_d;
  logic [`DMS_P_W-1:0] pc_q, pc_d;
  logic [`DMS_LANES-1:0] cy_q, cy_d;
  logic pm_q, pm_d;
  logic pb_q, pb_d;

  // Input stage: hold operands while the clock enable is low
  always_comb begin
    a_d = a_q;
    d_d = d_q;
    b_d = b_q;
    c_d = c_q;
    ab_d = ab_q;
    if (ce) begin
      a_d = a_in;
      d_d = d_in;
      b_d = b_in;
      c_d = c_in;
      ab_d = ab_in;
    end
  end

  // Input stage registers, cleared by the synchronous reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      a_q <= `DMS_A_RST;
      d_q <= `DMS_A_RST;
      b_q <= `DMS_B_RST;
      c_q <= `DMS_P_RST;
      ab_q <= `DMS_P_RST;
    end else begin
      a_q <= a_d;
      d_q <= d_d;
      b_q <= b_d;
      c_q <= c_d;
      ab_q <= ab_d;
    end
  end

  // Pre-adder and multiplier; a symmetric tap pair shares one multiply
  always_comb begin
    pre_val = a_q; // Pre-adder off: A passes
    if (preadd_en) begin
      pre_val = preadd_sub ? (a_q - d_q) : (a_q + d_q);
    end
    // Both operands signed; 25+18 bits hold the product without loss
    prod = `DMS_M_W'($signed(pre_val) * $signed(b_q));
    m_d = ce ? prod : m_q;
    // Skipping the pipeline register saves a cycle of latency at the cost of clock rate
    m_sel = use_mreg ? m_q : prod;
  end

  // Multiplier pipeline register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      m_q <= `DMS_M_RST;
    end else begin
      m_q <= m_d;
    end
  end

  // Operand select, logic unit, lane adder, pattern detector and rounding
  always_comb begin
    // X: sign-extended product, or the wide operand when bypassed
    x_op = mul_bypass ? ab_q : {{`DMS_EXT_W{m_sel[`DMS_M_W-1]}}, m_sel};
    // Z source; clear turns accumulate into a plain load
    case (zsel)
      dms_pkg::DMS_Z_ACC: z_op = clr ? '0 : p_q;
      dms_pkg::DMS_Z_C: z_op = c_q;
      dms_pkg::DMS_Z_CAS: z_op = pcin;
      default: z_op = '0;
    endcase
    // Counter ops always count from the stored value unless cleared
    if ((op == dms_pkg::DMS_OP_INC) || (op == dms_pkg::DMS_OP_DEC)) begin
      z_op = clr ? '0 : p_q;
    end
    // Ten bitwise functions
    case (lfn)
      dms_pkg::DMS_LF_AND: logic_val = x_op & z_op;
      dms_pkg::DMS_LF_OR: logic_val = x_op | z_op;
      dms_pkg::DMS_LF_XOR: logic_val = x_op ^ z_op;
      dms_pkg::DMS_LF_XNOR: logic_val = ~(x_op ^ z_op);
      dms_pkg::DMS_LF_NAND: logic_val = ~(x_op & z_op);
      dms_pkg::DMS_LF_NOR: logic_val = ~(x_op | z_op);
      dms_pkg::DMS_LF_ANDN: logic_val = x_op & ~z_op;
      dms_pkg::DMS_LF_ORN: logic_val = x_op | ~z_op;
      dms_pkg::DMS_LF_NOTX: logic_val = ~x_op;
      dms_pkg::DMS_LF_PASSX: logic_val = x_op;
      default: logic_val = '0;
    endcase
    // Arithmetic; lanes keep carries to themselves
    case (op)
      dms_pkg::DMS_OP_SUB: sum_val = lane_add(x_op, z_op, 1'b1, simd);
      dms_pkg::DMS_OP_INC: sum_val = lane_add(lane_one(simd), z_op, 1'b0, simd);
      dms_pkg::DMS_OP_DEC: sum_val = lane_add(lane_one(simd), z_op, 1'b1, simd);
      default: sum_val = lane_add(x_op, z_op, 1'b0, simd);
    endcase
    raw_val = (op == dms_pkg::DMS_OP_LOGIC) ? logic_val : sum_val[`DMS_P_W-1:0];
    // A 48-bit reduction after a 48+48 logic function gives a 96-input function
    raw_hit = pat_hit(raw_val, pattern, pmask);
    p_d = p_q;
    pc_d = pc_q;
    cy_d = cy_q;
    pm_d = pm_q;
    pb_d = pb_q;
    if (ce) begin
      p_d = raw_val;
      // On an exact tie the round bit is cleared, giving round-to-even
      if (round_en && raw_hit) begin
        p_d[round_pos] = 1'b0;
      end
      pc_d = p_d;
      cy_d = (op == dms_pkg::DMS_OP_LOGIC) ? '0 : sum_val[`DMS_P_W +: `DMS_LANES];
      pm_d = raw_hit;
      pb_d = pat_hit(raw_val, ~pattern, pmask);
    end
  end

  // Result, cascade and flag registers; outputs come straight from here
  always_ff @(posedge clk) begin
    if (!resetn) begin
      p_q <= `DMS_P_RST;
      pc_q <= `DMS_P_RST;
      cy_q <= `DMS_CY_RST;
      pm_q <= 1'b0;
      pb_q <= 1'b0;
    end else begin
      p_q <= p_d;
      pc_q <= pc_d;
      cy_q <= cy_d;
      pm_q <= pm_d;
      pb_q <= pb_d;
    end
  end

  assign p_out = p_q;
  assign pcout = pc_q;
  assign carry_out = cy_q;
  assign pattern_match = pm_q;
  assign pattern_bmatch = pb_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Plain full-width add step with no rounding interference
  sequence s_plain_add;
    ce && (op == dms_pkg::DMS_OP_ADD) && (simd == dms_pkg::DMS_SIMD_ONE48) && !round_en;
  endsequence

  sequence s_logic_and_all;
    ce && (op == dms_pkg::DMS_OP_LOGIC) && (lfn == dms_pkg::DMS_LF_AND) &&
      (pmask == '0) && (pattern == {`DMS_P_W{1'b1}});
  endsequence

  mult_product_a: assert property (ce && !preadd_en |=>
    m_q == `DMS_M_W'($signed($past(a_q)) * $signed($past(b_q))))
    else $error("product register does not hold signed A times B");

  preadd_sum_a: assert property (ce && preadd_en && !preadd_sub |=>
    m_q == `DMS_M_W'($signed(`DMS_A_W'($past(a_q) + $past(d_q))) * $signed($past(b_q))))
    else $error("pre-added operand not multiplied");

  acc_add_a: assert property (s_plain_add and zsel == dms_pkg::DMS_Z_ACC && !clr |=>
    p_out == $past(p_out) + $past(x_op))
    else $error("accumulator did not add to stored sum");

  bypass_add_a: assert property (s_plain_add and mul_bypass && zsel == dms_pkg::DMS_Z_C |=>
    p_out == $past(ab_q) + $past(c_q))
    else $error("bypassed operands not summed");

  lane_split_a: assert property (ce && !round_en && op == dms_pkg::DMS_OP_ADD &&
    simd == dms_pkg::DMS_SIMD_FOUR12 |=>
    p_out[23:12] == 12'($past(x_op[23:12]) + $past(z_op[23:12])))
    else $error("carry crossed a 12-bit lane");

  logic_xor_a: assert property (ce && !round_en && op == dms_pkg::DMS_OP_LOGIC &&
    lfn == dms_pkg::DMS_LF_XOR |=> p_out == ($past(x_op) ^ $past(z_op)))
    else $error("logic unit xor wrong");

  pattern_flag_a: assert property (resetn && ce && !round_en |=>
    pattern_match == &(~(p_out ^ $past(pattern)) | $past(pmask)))
    else $error("pattern flag disagrees with result");

  wide_logic_a: assert property (s_logic_and_all and !round_en |=>
    pattern_match == (($past(x_op) & $past(z_op)) == {`DMS_P_W{1'b1}}))
    else $error("96-input and not reported");

  count_up_a: assert property (ce && !clr && !round_en && op == dms_pkg::DMS_OP_INC &&
    simd == dms_pkg::DMS_SIMD_ONE48 ##1 ce && !clr && !round_en &&
    op == dms_pkg::DMS_OP_INC && simd == dms_pkg::DMS_SIMD_ONE48 |=>
    p_out == $past(p_out, 2) + 48'h2)
    else $error("counter did not step by one per enabled edge");

  cascade_in_a: assert property (s_plain_add and zsel == dms_pkg::DMS_Z_CAS |=>
    pcout == $past(x_op) + $past(pcin) && pcout == p_out)
    else $error("cascade path wrong");

  clear_load_a: assert property (s_plain_add and clr && zsel == dms_pkg::DMS_Z_ACC |=>
    p_out == $past(x_op))
    else $error("clear did not load current result");

endmodule

// >>> verilog/dms_slice_regs.svh
// Constants for the multiply-accumulate slice: widths, lane layout, reset values.
// Assumes it is included by bare name and holds definitions only.
`ifndef DMS_SLICE_REGS_SVH
`define DMS_SLICE_REGS_SVH

// Operand widths of the multiplier and pre-adder
`define DMS_A_W 25
`define DMS_B_W 18
`define DMS_M_W 43
// Width of the arithmetic path, accumulator and cascade buses
`define DMS_P_W 48
// Sign-extension width from product to arithmetic path
`define DMS_EXT_W 5
// SIMD lane layout: four chunks of twelve bits
`define DMS_LANE_W 12
`define DMS_LANES 4
// Chunk index where the upper 24-bit lane starts
`define DMS_HALF_CHUNK 2
// Width of the rounding bit position
`define DMS_RPOS_W 6
// Reset values of the pipeline registers
`define DMS_A_RST 25'h0
`define DMS_B_RST 18'h0
`define DMS_M_RST 43'h0
`define DMS_P_RST 48'h0
`define DMS_CY_RST 4'h0

`endif

// >>> verilog/dms_pkg.sv
// Types for the multiply-accumulate slice: operations, operand selects, lane modes,
// logic functions. Assumes no surroundings beyond the compile order.
package dms_pkg;

  // Arithmetic/logic unit operation
  typedef enum logic [2:0] {
    DMS_OP_ADD   = 3'h0, // Z + X
    DMS_OP_SUB   = 3'h1, // Z - X
    DMS_OP_INC   = 3'h2, // Counter up, one per lane
    DMS_OP_DEC   = 3'h3, // Counter down, one per lane
    DMS_OP_LOGIC = 3'h4  // Bitwise function of X and Z
  } dms_op_e;

  // Source of the Z operand
  typedef enum logic [1:0] {
    DMS_Z_ZERO = 2'h0, // Constant zero
    DMS_Z_ACC  = 2'h1, // Own result register (accumulate)
    DMS_Z_C    = 2'h2, // Registered C operand
    DMS_Z_CAS  = 2'h3  // Cascade input from the neighbour slice
  } dms_zsel_e;

  // Lane split of the 48-bit path
  typedef enum logic [1:0] {
    DMS_SIMD_ONE48 = 2'h0,
    DMS_SIMD_TWO24 = 2'h1,
    DMS_SIMD_FOUR12 = 2'h2
  } dms_simd_e;

  // The ten bitwise functions of the logic unit
  typedef enum logic [3:0] {
    DMS_LF_AND   = 4'h0,
    DMS_LF_OR    = 4'h1,
    DMS_LF_XOR   = 4'h2,
    DMS_LF_XNOR  = 4'h3,
    DMS_LF_NAND  = 4'h4,
    DMS_LF_NOR   = 4'h5,
    DMS_LF_ANDN  = 4'h6, // X and not Z
    DMS_LF_ORN   = 4'h7, // X or not Z
    DMS_LF_NOTX  = 4'h8,
    DMS_LF_PASSX = 4'h9
  } dms_lfn_e;

endpackage

// >>> bench/dms_fabric_nbr.sv
// Neighbour slice model in the fabric: drives the cascade bus into the slice.
// Assumes the same clock and synchronous active-low reset as the slice.
`timescale 1ns/1ps
module dms_fabric_nbr (
  input wire logic clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [47:0] val,
  output logic [47:0] pcout
);
  logic [47:0] pc_q; // Registered result, as a real neighbour would present it
  logic [47:0] pc_d;

  // Next value: load a new result only when asked
  always_comb begin
    pc_d = load ? val : pc_q;
  end

  // Register only; the bus never changes mid-cycle
  always_ff @(posedge clk) begin
    pc_q <= !resetn ? 48'h0 : pc_d;
  end

  assign pcout = pc_q;
endmodule

// >>> bench/dms_slice_test.sv
// Self-checking bench for the multiply-accumulate slice.
// Assumes the design files compile first; a neighbour model feeds the cascade input.
`timescale 1ns/1ps
module dms_slice_test;
  logic clk = 1'b0; // 20 MHz
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [24:0] a_in = 25'h0;
  logic [24:0] d_in = 25'h0;
  logic [17:0] b_in = 18'h0;
  logic [47:0] c_in = 48'h0;
  logic [47:0] ab_in = 48'h0;
  logic [47:0] pcin;
  logic preadd_en = 1'b0;
  logic preadd_sub = 1'b0;
  logic use_mreg = 1'b0;
  logic mul_bypass = 1'b0;
  logic clr = 1'b0;
  dms_pkg::dms_op_e op = dms_pkg::DMS_OP_ADD;
  dms_pkg::dms_zsel_e zsel = dms_pkg::DMS_Z_ZERO;
  dms_pkg::dms_simd_e simd = dms_pkg::DMS_SIMD_ONE48;
  dms_pkg::dms_lfn_e lfn = dms_pkg::DMS_LF_AND;
  logic [47:0] pattern = 48'h0;
  logic [47:0] pmask = 48'h0;
  logic round_en = 1'b0;
  logic [5:0] round_pos = 6'h0;
  logic [47:0] p_out;
  logic [47:0] pcout;
  logic [3:0] carry_out;
  logic pattern_match;
  logic pattern_bmatch;
  logic nbr_load = 1'b0; // Neighbour model controls
  logic [47:0] nbr_val = 48'h0;
  int n_errors = 0;
  int samples_checked = 0;

  always #25 clk = ~clk;

  dms_slice i_dut (.clk(clk), .resetn(resetn), .ce(ce), .a_in(a_in), .d_in(d_in),
    .b_in(b_in), .c_in(c_in), .ab_in(ab_in), .pcin(pcin), .preadd_en(preadd_en),
    .preadd_sub(preadd_sub), .use_mreg(use_mreg), .mul_bypass(mul_bypass), .clr(clr),
    .op(op), .zsel(zsel), .simd(simd), .lfn(lfn), .pattern(pattern), .pmask(pmask),
    .round_en(round_en), .round_pos(round_pos), .p_out(p_out), .pcout(pcout),
    .carry_out(carry_out), .pattern_match(pattern_match), .pattern_bmatch(pattern_bmatch));

  dms_fabric_nbr i_nbr (.clk(clk), .resetn(resetn), .load(nbr_load), .val(nbr_val),
    .pcout(pcin));

  // Compare one value and count it
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Let the longest path (product register) settle, then sample off the edge
  task automatic go;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // Reference bitwise functions, written apart from the design's own
  function automatic logic [47:0] lf_ref(input int f, input logic [47:0] x,
    input logic [47:0] z);
    case (f)
      0: return x & z;
      1: return x | z;
      2: return x ^ z;
      3: return ~(x ^ z);
      4: return ~(x & z);
      5: return ~(x | z);
      6: return x & ~z;
      7: return x | ~z;
      8: return ~x;
      default: return x;
    endcase
  endfunction

  task automatic tally_and_finish;
    $display("checked %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Signed products, extreme corner, pre-adder both ways, product register
  task automatic t_mult;
    @(posedge clk);
    a_in <= 25'h1FFFFFD;
    b_in <= 18'h00007;
    go;
    check(p_out, 48'hFFFFFFFFFFEB);
    check(pcout, 48'hFFFFFFFFFFEB);
    @(posedge clk);
    use_mreg <= 1'b1;
    preadd_en <= 1'b1;
    preadd_sub <= 1'b1;
    d_in <= 25'h0000005;
    go;
    check(p_out, 48'hFFFFFFFFFFC8);
    @(posedge clk);
    preadd_sub <= 1'b0;
    go;
    check(p_out, 48'h00000000000E);
    @(posedge clk);
    preadd_en <= 1'b0;
    a_in <= 25'h1000000;
    b_in <= 18'h20000;
    go;
    check(p_out, 48'h020000000000);
    $display("test mult done");
  endtask

  // Bypass, three lane splits, add and subtract: lane carries must not cross
  task automatic t_simd;
    logic [47:0] tab [6] = '{48'h001001001000, 48'h001000001000, 48'h000000000000,
      48'h001001001002, 48'h001002001002, 48'h002002002002};
    @(posedge clk);
    use_mreg <= 1'b0;
    mul_bypass <= 1'b1;
    zsel <= dms_pkg::DMS_Z_C;
    ab_in <= 48'hFFFFFFFFFFFF;
    c_in <= 48'h001001001001;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      simd <= dms_pkg::dms_simd_e'(i % 3);
      op <= (i < 3) ? dms_pkg::DMS_OP_ADD : dms_pkg::DMS_OP_SUB;
      go;
      check(p_out, tab[i]);
      if (i < 3) check({44'h0, carry_out}, 48'h00000000000F);
    end
    @(posedge clk);
    simd <= dms_pkg::DMS_SIMD_ONE48;
    $display("test simd done");
  endtask

  // All ten logic functions; the detector on the logic result gives a 96-bit function
  task automatic t_logic;
    @(posedge clk);
    op <= dms_pkg::DMS_OP_LOGIC;
    ab_in <= 48'hCCCCCCCCCCCC;
    c_in <= 48'hAAAAAAAAAAAA;
    for (int f = 0; f < 10; f++) begin
      @(posedge clk);
      lfn <= dms_pkg::dms_lfn_e'(f);
      pattern <= lf_ref(f, 48'hCCCCCCCCCCCC, 48'hAAAAAAAAAAAA);
      go;
      check(p_out, lf_ref(f, 48'hCCCCCCCCCCCC, 48'hAAAAAAAAAAAA));
      check({47'h0, pattern_match}, 48'h1);
      check({47'h0, pattern_bmatch}, 48'h0);
    end
    // All-ones pattern on an AND result: one flag over 96 input bits
    @(posedge clk);
    lfn <= dms_pkg::DMS_LF_AND;
    pattern <= 48'hFFFFFFFFFFFF;
    ab_in <= 48'hFFFFFFFFFFFF;
    c_in <= 48'hFFFFFFFFFFFF;
    go;
    check({47'h0, pattern_match}, 48'h1);
    @(posedge clk);
    c_in <= 48'hFFFFFFFFFFFE;
    go;
    check({47'h0, pattern_match}, 48'h0);
    $display("test logic done");
  endtask

  // Clear, accumulate, freeze, then count up and down
  task automatic t_acc;
    @(posedge clk);
    op <= dms_pkg::DMS_OP_ADD;
    zsel <= dms_pkg::DMS_Z_ACC;
    ab_in <= 48'h5;
    clr <= 1'b1;
    go;
    check(p_out, 48'h5);
    @(posedge clk);
    clr <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(p_out, 48'h14);
    @(posedge clk);
    ce <= 1'b0;
    go;
    check(p_out, 48'h19);
    @(posedge clk);
    ce <= 1'b1;
    op <= dms_pkg::DMS_OP_INC;
    clr <= 1'b1;
    go;
    check(p_out, 48'h1);
    @(posedge clk);
    clr <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(p_out, 48'h4);
    @(posedge clk);
    op <= dms_pkg::DMS_OP_DEC;
    clr <= 1'b1;
    go;
    check(p_out, 48'hFFFFFFFFFFFF);
    @(posedge clk);
    clr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(p_out, 48'hFFFFFFFFFFFD);
    @(posedge clk);
    simd <= dms_pkg::DMS_SIMD_FOUR12;
    op <= dms_pkg::DMS_OP_INC;
    clr <= 1'b1;
    go;
    check(p_out, 48'h001001001001);
    @(posedge clk);
    clr <= 1'b0;
    simd <= dms_pkg::DMS_SIMD_ONE48;
    $display("test acc done");
  endtask

  // Masked match, rounding fix-up, inverted match, then cascade input
  task automatic t_round_cas;
    @(posedge clk);
    op <= dms_pkg::DMS_OP_ADD;
    zsel <= dms_pkg::DMS_Z_ZERO;
    ab_in <= 48'h30;
    pattern <= 48'h10;
    pmask <= 48'hFFFFFFFFFFE0;
    go;
    check(p_out, 48'h30);
    check({47'h0, pattern_match}, 48'h1);
    @(posedge clk);
    round_en <= 1'b1;
    round_pos <= 6'h04;
    go;
    check(p_out, 48'h20);
    @(posedge clk);
    ab_in <= 48'h2F;
    go;
    check(p_out, 48'h2F);
    check({46'h0, pattern_match, pattern_bmatch}, 48'h1);
    @(posedge clk);
    round_en <= 1'b0;
    nbr_load <= 1'b1;
    nbr_val <= 48'h123456789ABC;
    zsel <= dms_pkg::DMS_Z_CAS;
    ab_in <= 48'h1;
    go;
    check(p_out, 48'h123456789ABD);
    check(pcout, 48'h123456789ABD);
    $display("test round and cascade done");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    #1;
    check(p_out, 48'h0);
    @(posedge clk);
    resetn <= 1'b1;
    t_mult;
    t_simd;
    t_logic;
    t_acc;
    t_round_cas;
    tally_and_finish;
  end

  // Watchdog: the tests need well under 400 cycles
  initial begin
    #(50 * 2000);
    n_errors++;
    $display("[ERR] %0t ns: watchdog expired", $time);
    tally_and_finish;
  end
endmodule
